// *** logic/ctm_core.sv ***
`timescale 1ns/1ns
// cycle timing, register gating and major-state control
module ctm_core (
	input  wire logic                  clk,              // clock
	input  wire logic                  rst,              // sync reset
	input  wire logic                  wb_cyc_i,         // bus cycle
	input  wire logic                  wb_stb_i,         // strobe
	input  wire logic                  wb_we_i,          // write
	input  wire logic [7:0]            wb_adr_i,         // byte address
	input  wire logic [31:0]           wb_dat_i,         // write data
	input  wire logic [3:0]            wb_sel_i,         // byte lanes
	output logic      [31:0]           wb_dat_o,         // read data
	output logic                       wb_ack_o,         // answer
	input  wire logic [11:0]           switchPins,       // toggles
	input  wire logic                  setLocationKey,   // console key
	input  wire logic                  storeWordKey,     // console key
	input  wire ctm_pkg::ctm_major_e   decodeNext,       // decoder wish
	input  wire logic                  breakRequest,     // data break
	input  wire logic                  skipRequest,      // skip cond
	input  wire logic                  interruptRequest, // service req
	input  wire logic [11:0]           externalData,     // interface
	output ctm_pkg::ctm_mem_req_s      memReq,           // to memory
	input  wire ctm_pkg::ctm_mem_rsp_s memRsp,           // from memory
	output logic      [3:0]            phaseLevel,       // levels
	output logic      [3:0]            phaseStrobe,      // strobes
	output logic      [5:0]            majorState,       // one-hot
	output logic      [11:0]           readWord          // to decoder
);
	logic [11:0] switchWord;   // console switch word
	logic [11:0] location;     // memory location register
	logic [11:0] buffer;       // write buffer register
	logic [11:0] capture;      // read-data capture register
	logic [11:0] pointer;      // program pointer
	logic [2:0]  ctrl;         // run, interrupt enable, break mode
	logic        prevSetKey;   // key history for edge detect
	logic        prevStoreKey;
	logic        skipLatched;  // skip owed in this fetch
	logic        intPending;   // interrupt entry in next fetch
	logic        readActive;   // memory read in flight
	logic        writeActive;  // memory write in flight
	logic        readDoneSeen; // read finished this cycle
	logic        writeDoneSeen;
	logic        reqRead;      // read start pulse to memory
	logic        reqWrite;     // write start pulse to memory
	logic [11:0] reqInhibit;   // per-bit inhibit toward memory
	logic        busy;         // a processor cycle is running
	ctm_pkg::ctm_src_e  src;   // bus source this clock
	ctm_pkg::ctm_major_e next_major;
	logic [11:0] regBus;       // common register input bus
	logic [12:0] carry;        // increment carry chain
	logic [5:0]  srcHot;       // one-hot form of src
	logic [31:0] readData;     // bus read mux

	// the switch word follows its toggles every clock
	always_ff @(posedge clk) begin
		if (rst) begin
			switchWord <= ctm_pkg::CTM_WORD_RESET;
		end else begin
			switchWord <= switchPins;
		end
	end

	// key presses: rising edges, honoured only while halted
	wire setRise   = setLocationKey & ~prevSetKey;
	wire storeRise = storeWordKey & ~prevStoreKey;
	wire keyLoad   = ~busy & (setRise | storeRise);

	// major-state decode
	wire inFetch   = majorState[ctm_pkg::MS_FETCH];
	wire inOperand = majorState[ctm_pkg::MS_DEFER]
		| majorState[ctm_pkg::MS_EXECUTE];
	wire inTally   = majorState[ctm_pkg::MS_TALLY];
	wire inPtrSt   = majorState[ctm_pkg::MS_POINTER];
	wire inBreak   = inTally | inPtrSt | majorState[ctm_pkg::MS_BREAK];

	// levels choose the source driven onto the bus
	wire [2:0] lateFetch = (intPending) ? ctm_pkg::SRC_NONE
		: ctm_pkg::SRC_POINTER;
	// first division: address source; break states take it
	// from the external interface
	wire [2:0] firstSrc = inFetch ? lateFetch
		: inOperand ? ctm_pkg::SRC_CAPTURE
		: ctm_pkg::SRC_EXTERNAL;
	// second division: restore the read word, take external data in
	// break states, or on interrupt entry save the pointer instead
	wire [2:0] secondSrc = (inFetch && intPending) ? ctm_pkg::SRC_POINTER
		: inBreak ? ctm_pkg::SRC_EXTERNAL
		: ctm_pkg::SRC_CAPTURE;
	wire [2:0] laterSrc = inFetch ? lateFetch : ctm_pkg::SRC_NONE;
	assign src = keyLoad ? ctm_pkg::SRC_SWITCH
		: phaseLevel[0] ? ctm_pkg::ctm_src_e'(firstSrc)
		: phaseLevel[1] ? ctm_pkg::ctm_src_e'(secondSrc)
		: (phaseLevel[2] | phaseLevel[3]) ? ctm_pkg::ctm_src_e'(laterSrc)
		: ctm_pkg::SRC_NONE;

	// one enable line per source position
	assign srcHot = {src == ctm_pkg::SRC_EXTERNAL,
		src == ctm_pkg::SRC_POINTER, src == ctm_pkg::SRC_CAPTURE,
		src == ctm_pkg::SRC_BUFFER, src == ctm_pkg::SRC_LOCATION,
		src == ctm_pkg::SRC_SWITCH};

	// increment in fetch only: third division always, fourth only to skip;
	// with no source on interrupt entry the pointer becomes one
	assign carry[0] = ~keyLoad & inFetch
		& (phaseLevel[2] | (phaseLevel[3] & skipLatched));

	// per-bit gate structures of the shared bus
	genvar gi;
	generate
		for (gi = 0; gi < ctm_pkg::CTM_W; gi++) begin : gSlice
			ctm_gate_slice uSlice (
				.srcBits  ({externalData[gi], pointer[gi], capture[gi],
					buffer[gi], location[gi], switchWord[gi]}),
				.srcHot   (srcHot),
				.carryIn  (carry[gi]),
				.busBit   (regBus[gi]),
				.carryOut (carry[gi+1])
			);
		end
	endgenerate

	// strobes and keys pick the destination register
	wire loadLocation = (keyLoad & setRise) | phaseStrobe[0];
	wire loadBuffer   = (keyLoad & storeRise) | phaseStrobe[1];
	wire loadPointer  = (keyLoad & setRise)
		| (inFetch & (phaseStrobe[2] | (phaseStrobe[3] & skipLatched)));

	// destination registers load only from the bus
	always_ff @(posedge clk) begin
		if (rst) begin
			location     <= ctm_pkg::CTM_WORD_RESET;
			buffer       <= ctm_pkg::CTM_WORD_RESET;
			pointer      <= ctm_pkg::CTM_WORD_RESET;
			prevSetKey   <= 1'b0;
			prevStoreKey <= 1'b0;
		end else begin
			prevSetKey   <= setLocationKey;
			prevStoreKey <= storeWordKey;
			if (loadLocation) begin
				location <= regBus;
			end
			if (loadBuffer) begin
				buffer <= regBus;
			end
			if (loadPointer) begin
				pointer <= regBus;
			end
		end
	end

	// division timing; memory may stretch divisions two and four
	ctm_phase_seq uSeq (
		.clk         (clk),
		.rst         (rst),
		.run         (ctrl[ctm_pkg::CTM_CTRL_RUN]),
		.mayEnd      ({writeDoneSeen, 1'b1, readDoneSeen, 1'b1}),
		.phaseLevel  (phaseLevel),
		.phaseStrobe (phaseStrobe),
		.busy        (busy)
	);

	// memory side: read after the address settles, write in T4
	always_ff @(posedge clk) begin
		if (rst) begin
			reqRead           <= 1'b0;
			reqWrite          <= 1'b0;
			reqInhibit        <= ctm_pkg::CTM_WORD_RESET;
			readActive        <= 1'b0;
			writeActive       <= 1'b0;
			readDoneSeen      <= 1'b0;
			writeDoneSeen     <= 1'b0;
			capture           <= ctm_pkg::CTM_WORD_RESET;
		end else begin
			reqRead  <= phaseStrobe[0];
			reqWrite <= phaseStrobe[2];
			if (reqRead) begin
				// fresh read: clear, then only ones are sensed
				capture    <= ctm_pkg::CTM_WORD_RESET;
				readActive <= 1'b1;
			end else if (readActive) begin
				if (memRsp.senseValid) begin
					capture <= capture | memRsp.sense;
				end
				if (memRsp.readDone) begin
					readActive <= 1'b0;
				end
			end
			if (phaseStrobe[2]) begin
				// the write would set every bit; hold back the zeros
				reqInhibit  <= ~buffer;
				writeActive <= 1'b1;
			end else if (writeActive && memRsp.writeDone) begin
				reqInhibit  <= ctm_pkg::CTM_WORD_RESET;
				writeActive    <= 1'b0;
			end
			// completion flags: a done in the clear cycle still counts
			if (phaseStrobe[1]) begin
				readDoneSeen <= 1'b0;
			end
			if (readActive && memRsp.readDone) begin
				readDoneSeen <= 1'b1;
			end
			if (phaseStrobe[3]) begin
				writeDoneSeen <= 1'b0;
			end
			if (writeActive && memRsp.writeDone) begin
				writeDoneSeen <= 1'b1;
			end
		end
	end

	// full address goes out; the array decodes one word
	assign memReq = '{location, reqRead, reqWrite, reqInhibit};
	assign readWord    = capture;

	// interrupt taken at the end of a fetch, never during a break
	wire intTake = phaseStrobe[3] & inFetch & ~breakRequest
		& ctrl[ctm_pkg::CTM_CTRL_INTEN] & interruptRequest;

	// break states chain tally, pointer, break; otherwise the
	// decoder asks, and anything but F, D or E falls back to fetch
	wire decodeOk = (decodeNext == ctm_pkg::MS_FETCH)
		| (decodeNext == ctm_pkg::MS_DEFER)
		| (decodeNext == ctm_pkg::MS_EXECUTE);
	assign next_major = inTally ? ctm_pkg::MS_POINTER
		: inPtrSt ? ctm_pkg::MS_BREAK
		: breakRequest ? (ctrl[ctm_pkg::CTM_CTRL_BRK3]
			? ctm_pkg::MS_TALLY : ctm_pkg::MS_BREAK)
		: intTake ? ctm_pkg::MS_FETCH
		: decodeOk ? decodeNext : ctm_pkg::MS_FETCH;

	// one-hot major state, replaced whole on the fourth strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			majorState <= ctm_pkg::CTM_MAJOR_RESET;
		end else if (phaseStrobe[3]) begin
			majorState <= 6'h01 << next_major;
		end
	end

	// skip and interrupt bookkeeping inside the fetch cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			skipLatched <= 1'b0;
			intPending  <= 1'b0;
		end else begin
			if (phaseStrobe[3]) begin
				skipLatched <= 1'b0;
			end
			if (inFetch && phaseLevel[2] && skipRequest) begin
				skipLatched <= 1'b1;
			end
			if (phaseStrobe[2] && inFetch) begin
				intPending <= 1'b0;
			end
			if (intTake) begin
				intPending <= 1'b1;
			end
		end
	end

	// bus slave: ack one clock after the request, for one clock
	wire wbReq   = wb_cyc_i & wb_stb_i;
	wire wbWrite = wbReq & wb_we_i & wb_ack_o;
	wire ctrlWr  = wbWrite & wb_sel_i[0]
		& (wb_adr_i == ctm_pkg::CTM_OFS_CTRL);
	wire [31:0] statusWord = {19'h00000, skipLatched, intPending, busy,
		phaseLevel, majorState};
	assign readData =
		(wb_adr_i == ctm_pkg::CTM_OFS_CTRL)     ? {29'h0, ctrl}
		: (wb_adr_i == ctm_pkg::CTM_OFS_STATUS)   ? statusWord
		: (wb_adr_i == ctm_pkg::CTM_OFS_SWITCH)   ? {20'h0, switchWord}
		: (wb_adr_i == ctm_pkg::CTM_OFS_LOCATION) ? {20'h0, location}
		: (wb_adr_i == ctm_pkg::CTM_OFS_BUFFER)   ? {20'h0, buffer}
		: (wb_adr_i == ctm_pkg::CTM_OFS_CAPTURE)  ? {20'h0, capture}
		: (wb_adr_i == ctm_pkg::CTM_OFS_POINTER)  ? {20'h0, pointer}
		: 32'h00000000; // unmapped reads zero, still acked

	// ack, read data and the control register
	always_ff @(posedge clk) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
			ctrl     <= ctm_pkg::CTM_CTRL_RESET;
		end else begin
			wb_ack_o <= wbReq & ~wb_ack_o;
			if (wbReq && !wb_ack_o) begin
				wb_dat_o <= readData;
			end
			// hardware drops enable on entry; a same-clock write wins
			if (intTake) begin
				ctrl[ctm_pkg::CTM_CTRL_INTEN] <= 1'b0;
			end
			if (ctrlWr) begin
				ctrl <= wb_dat_i[2:0];
			end
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (rst);

	AST_ONE_MAJOR: assert property ($onehot(majorState))
		else $error("major state not one-hot");
	AST_MAJOR_AT_T4: assert property (
		majorState != $past(majorState) |-> $past(phaseStrobe[3]))
		else $error("major state changed off the fourth strobe");
	AST_STROBE_IN_LEVEL: assert property (
		$onehot0(phaseStrobe) && ((phaseStrobe & ~phaseLevel) == 4'h0))
		else $error("strobe outside its division");
	AST_NEXT_DIVISION: assert property (
		phaseStrobe[0] |=> phaseLevel == 4'h2)
		else $error("division two did not follow one");
	AST_SET_KEY: assert property (
		keyLoad && setRise |=> location == $past(switchWord)
			&& pointer == $past(switchWord))
		else $error("set-location key did not load");
	AST_STORE_KEY: assert property (
		keyLoad && storeRise |=> buffer == $past(switchWord))
		else $error("store key did not load buffer");
	AST_INHIBIT: assert property (
		phaseStrobe[2] |=> memReq.inhibit == ~$past(buffer)
			&& memReq.writeStart)
		else $error("inhibit does not mirror buffer zeros");
	AST_SENSE_SETS: assert property (
		readActive && !memReq.readStart && memRsp.senseValid
		|=> (capture & $past(memRsp.sense)) == $past(memRsp.sense))
		else $error("sensed bit not captured");
	AST_READ_WAIT: assert property (
		phaseStrobe[1] |-> readDoneSeen && !readActive && !reqRead)
		else $error("division two ended before read done");
	AST_FETCH_ADDR: assert property (
		phaseStrobe[0] && inFetch && !intPending
		|=> location == $past(pointer) && memReq.readStart)
		else $error("fetch address not from pointer");

	COV_SKIP: cover property (phaseStrobe[3] && skipLatched);
	COV_BREAK: cover property (phaseStrobe[3] && inBreak);
	COV_INT: cover property (intTake ##[1:800] phaseStrobe[2]);
endmodule

// *** logic/ctm_pkg.sv ***
package ctm_pkg;
	localparam int CTM_W          = 12;   // word width
	localparam int CTM_CLK_NS     = 4;    // clock period
	localparam int CTM_CYCLE_NS   = 1600; // nominal processor cycle
	localparam int CTM_DIV_NUM    = 4;    // divisions per cycle
	localparam int CTM_DIV_NS     = CTM_CYCLE_NS / CTM_DIV_NUM;
	// least division length, rounded up to whole clocks
	localparam int CTM_DIV_CYCLES = (CTM_DIV_NS + CTM_CLK_NS - 1)
		/ CTM_CLK_NS;
	localparam logic [6:0] CTM_DIV_LAST = 7'(CTM_DIV_CYCLES - 1);

	// register byte offsets
	localparam logic [7:0] CTM_OFS_CTRL     = 8'h00;
	localparam logic [7:0] CTM_OFS_STATUS   = 8'h04;
	localparam logic [7:0] CTM_OFS_SWITCH   = 8'h08;
	localparam logic [7:0] CTM_OFS_LOCATION = 8'h0C;
	localparam logic [7:0] CTM_OFS_BUFFER   = 8'h10;
	localparam logic [7:0] CTM_OFS_CAPTURE  = 8'h14;
	localparam logic [7:0] CTM_OFS_POINTER  = 8'h18;

	// control register fields
	localparam int CTM_CTRL_RUN   = 0;
	localparam int CTM_CTRL_INTEN = 1;
	localparam int CTM_CTRL_BRK3  = 2;
	localparam logic [2:0] CTM_CTRL_RESET = 3'h0;
	localparam logic [11:0] CTM_WORD_RESET = 12'h000;

	// major states, used as bit index of the one-hot vector
	typedef enum logic [2:0] {
		MS_FETCH   = 3'h0,
		MS_DEFER   = 3'h1,
		MS_EXECUTE = 3'h2,
		MS_TALLY   = 3'h3,
		MS_POINTER = 3'h4,
		MS_BREAK   = 3'h5
	} ctm_major_e;
	localparam logic [5:0] CTM_MAJOR_RESET = 6'h01;

	// sources of the shared register bus
	typedef enum logic [2:0] {
		SRC_NONE     = 3'h0,
		SRC_SWITCH   = 3'h1,
		SRC_LOCATION = 3'h2,
		SRC_BUFFER   = 3'h3,
		SRC_CAPTURE  = 3'h4,
		SRC_POINTER  = 3'h5,
		SRC_EXTERNAL = 3'h6
	} ctm_src_e;

	// division sequencer states
	typedef enum logic {
		SEQ_IDLE = 1'b0,
		SEQ_RUN  = 1'b1
	} ctm_seq_e;

	// requests toward the core memory
	typedef struct packed {
		logic [11:0] addr;
		logic        readStart;
		logic        writeStart;
		logic [11:0] inhibit;
	} ctm_mem_req_s;

	// answers from the core memory
	typedef struct packed {
		logic [11:0] sense;
		logic        senseValid;
		logic        readDone;
		logic        writeDone;
	} ctm_mem_rsp_s;
endpackage

// *** logic/ctm_gate_slice.sv ***
`timescale 1ns/1ns
// one bit position of the gating network
module ctm_gate_slice (
	input  wire logic [5:0] srcBits,  // this bit of every source
	input  wire logic [5:0] srcHot,   // one-hot source select
	input  wire logic       carryIn,  // increment carry from below
	output logic            busBit,   // bus value of this bit
	output logic            carryOut  // carry to the next bit
);
	// or of the enabled sources, then the half adder
	wire gated = |(srcBits & srcHot);
	assign busBit   = gated ^ carryIn;
	assign carryOut = gated & carryIn;
endmodule

// *** logic/ctm_phase_seq.sv ***
`timescale 1ns/1ns
// four-division timing chain of one processor cycle
module ctm_phase_seq (
	input  wire logic       clk,         // system clock
	input  wire logic       rst,         // synchronous reset
	input  wire logic       run,         // keep cycling
	input  wire logic [3:0] mayEnd,      // memory lets division end
	output logic      [3:0] phaseLevel,  // division levels
	output logic      [3:0] phaseStrobe, // end-of-division pulses
	output logic            busy         // a cycle is in progress
);
	ctm_pkg::ctm_seq_e state;   // idle or cycling
	logic [6:0]        divCount; // clocks spent in this division

	// minimum division time reached
	wire divDone = (divCount >= ctm_pkg::CTM_DIV_LAST);

	// strobe ends a division only once memory agrees
	assign phaseStrobe = phaseLevel & {4{divDone}} & mayEnd;
	assign busy = (state == ctm_pkg::SEQ_RUN);

	// a halt only takes effect at the end of the fourth division,
	// so the memory is never left halfway through a cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			state      <= ctm_pkg::SEQ_IDLE;
			phaseLevel <= 4'h0;
			divCount   <= 7'h00;
		end else begin
			case (state)
				ctm_pkg::SEQ_IDLE: begin
					if (run) begin
						state      <= ctm_pkg::SEQ_RUN;
						phaseLevel <= 4'h1;
						divCount   <= 7'h00;
					end
				end
				ctm_pkg::SEQ_RUN: begin
					if (|phaseStrobe) begin
						divCount <= 7'h00;
						if (phaseStrobe[3] && !run) begin
							state      <= ctm_pkg::SEQ_IDLE;
							phaseLevel <= 4'h0;
						end else begin
							// next division, wrapping to the first
							phaseLevel <= {phaseLevel[2:0],
								phaseLevel[3]};
						end
					end else if (!divDone) begin
						// fixed delay of the division
						divCount <= divCount + 7'h01;
					end
				end
				default: begin
					state      <= ctm_pkg::SEQ_IDLE;
					phaseLevel <= 4'h0;
				end
			endcase
		end
	end
endmodule

// *** sim/ctm_mem_model.sv ***
`timescale 1ns/1ns
// behavioural core memory: destructive read, write restored by inhibit
module ctm_mem_model (
	input  wire logic                  clk,     // clock
	input  wire logic                  rst,     // sync reset
	input  wire logic [7:0]            latency, // clocks before answer
	input  wire ctm_pkg::ctm_mem_req_s req,     // from controller
	output ctm_pkg::ctm_mem_rsp_s      rsp      // to controller
);
	logic [11:0] mem [4096]; // twelve-bit words, no parity plane
	logic [7:0]  waitCnt;    // answer delay
	logic        rdBusy;     // read portion running
	logic        wrBusy;     // write portion running
	logic [11:0] opAddr;     // whole address picks one word

	// distinct contents so that a wrong address shows up
	initial begin
		rsp = '0;
		for (int i = 0; i < 4096; i++) begin
			mem[i] = 12'(i * 5) ^ 12'hA5A;
		end
	end

	// answer each start only after the latency has run out
	always @(posedge clk) begin
		rsp.readDone <= 1'b0;
		rsp.writeDone <= 1'b0;
		rsp.senseValid <= 1'b0;
		// sense lines float outside a strobe: keep them changing
		rsp.sense <= ~rsp.sense;
		if (rst) begin
			rdBusy <= 1'b0;
			wrBusy <= 1'b0;
			waitCnt <= 8'h00;
		end else if (req.readStart) begin
			rdBusy <= 1'b1;
			opAddr <= req.addr;
			waitCnt <= latency;
		end else if (req.writeStart) begin
			wrBusy <= 1'b1;
			opAddr <= req.addr;
			waitCnt <= latency;
		end else if (waitCnt != 8'h00) begin
			waitCnt <= waitCnt - 8'h01;
		end else if (rdBusy) begin
			// reading clears the cores; only the write puts data back
			rsp.sense <= mem[opAddr];
			rsp.senseValid <= 1'b1;
			rsp.readDone <= 1'b1;
			mem[opAddr] <= 12'h000;
			rdBusy <= 1'b0;
		end else if (wrBusy) begin
			// every bit goes to one unless inhibited
			mem[opAddr] <= ~req.inhibit;
			rsp.writeDone <= 1'b1;
			wrBusy <= 1'b0;
		end
	end
endmodule

// *** sim/tb.sv ***
`timescale 1ns/1ns
// self-checking bench for the cycle timing controller
module tb;
	typedef struct packed {
		logic [11:0] sw;  // toggles
		logic        l;   // set-location key
		logic        s;   // store key
		logic [11:0] loc; // location afterwards
		logic [11:0] bw;  // buffer afterwards
	} ctm_tb_row_s;
	ctm_tb_row_s rows [4] = '{'{12'hFFF, 1'b1, 1'b1, 12'hFFF, 12'hFFF},
		'{12'h000, 1'b1, 1'b0, 12'h000, 12'hFFF},
		'{12'hA5A, 1'b0, 1'b1, 12'h000, 12'hA5A},
		'{12'h5A5, 1'b1, 1'b1, 12'h5A5, 12'h5A5}};
	logic                  clk = 1'b0;       // 250 MHz
	logic                  rst = 1'b1;       // reset
	logic                  cyc = 1'b0;       // bus request
	logic                  stb = 1'b0;       // bus request
	logic                  we = 1'b0;        // bus direction
	logic [7:0]            adr = 8'h00;      // bus address
	logic [31:0]           wdat = 32'h0;     // bus write data
	logic [3:0]            sel = 4'h0;       // byte lanes
	logic [11:0]           pins = 12'h000;   // console toggles
	logic                  keyLoc = 1'b0;    // console key
	logic                  keyStore = 1'b0;  // console key
	logic                  brk = 1'b0;       // data break, raised in the break test
	logic                  skip = 1'b0;      // skip condition
	logic                  irq = 1'b0;       // no service request here
	logic [11:0]           ext = 12'h000;    // interface word
	logic [7:0]            latency = 8'h02;  // memory answer delay
	ctm_pkg::ctm_major_e   decodeNext = ctm_pkg::MS_FETCH;
	logic [31:0]           rdat;             // bus read data
	logic                  ack;              // bus answer
	ctm_pkg::ctm_mem_req_s memReq;           // to memory
	ctm_pkg::ctm_mem_rsp_s memRsp;           // from memory
	logic [3:0]            lvl;              // division levels
	logic [3:0]            strobe;           // division strobes
	logic [5:0]            major;            // one-hot major state
	logic [11:0]           readWord;         // capture register
	logic [31:0]           q;                // scratch read value
	int                    fail_count = 0;   // mismatches
	int                    check_count = 0;  // comparisons
	int                    cycles = 0;       // timeout counter
	int                    nStrobe = 0;      // strobes seen
	int                    divCnt = 0;       // clocks in a division

	ctm_core DUT (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_sel_i(sel),
		.wb_dat_o(rdat), .wb_ack_o(ack), .switchPins(pins),
		.setLocationKey(keyLoc), .storeWordKey(keyStore),
		.decodeNext(decodeNext), .breakRequest(brk), .skipRequest(skip),
		.interruptRequest(irq), .externalData(ext), .memReq(memReq),
		.memRsp(memRsp), .phaseLevel(lvl), .phaseStrobe(strobe),
		.majorState(major), .readWord(readWord));
	ctm_mem_model mdl (.clk(clk), .rst(rst), .latency(latency),
		.req(memReq), .rsp(memRsp));

	always #2 clk = ~clk;

	// expected preset memory contents
	function automatic logic [11:0] pat(input logic [11:0] a);
		return 12'(a * 12'h005) ^ 12'hA5A;
	endfunction

	task automatic chk(input string what, input logic [31:0] exp,
		input logic [31:0] got);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// one classic bus cycle; held until ack is sampled high
	task automatic wbx(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 64);
		if (n >= 64) begin
			fail_count++;
			end_of_test();
		end
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input string what);
		logic [31:0] r;
		wbx(1'b0, a, 32'h0, r);
		chk(what, e, r);
	endtask

	// key press lasts one clock; switch word lags the pins
	task automatic press(input logic l, input logic s);
		repeat (2) @(posedge clk);
		keyLoc <= l;
		keyStore <= s;
		@(posedge clk);
		keyLoc <= 1'b0;
		keyStore <= 1'b0;
		repeat (2) @(posedge clk);
	endtask

	// start one cycle, ask for halt, wait for the fourth strobe
	task automatic run_cycle(input logic [7:0] lat,
		input ctm_pkg::ctm_major_e dn, input logic sk);
		int n;
		logic [31:0] r;
		n = 0;
		latency <= lat;
		decodeNext <= dn;
		skip <= sk;
		wbx(1'b1, ctm_pkg::CTM_OFS_CTRL, 32'h1, r);
		wbx(1'b1, ctm_pkg::CTM_OFS_CTRL, 32'h0, r);
		do begin
			@(posedge clk);
			n++;
		end while (strobe !== 4'h8 && n < 4000);
		if (n >= 4000) begin
			fail_count++;
			end_of_test();
		end
		repeat (4) @(posedge clk);
	endtask

	// watch strobe order, level overlap and division length
	always @(posedge clk) begin
		if (rst) begin
			nStrobe = 0;
			divCnt = 0;
		end else if (|strobe) begin
			chk("strobe", 32'h1 << (nStrobe % 4), 32'(strobe));
			chk("level", 32'(strobe), 32'(strobe & lvl));
			chk("div len", 32'h1,
				32'(divCnt + 1 >= ctm_pkg::CTM_DIV_CYCLES));
			chk("one major", 32'h1, 32'($onehot(major)));
			nStrobe++;
			divCnt = 0;
		end else if (|lvl) begin
			divCnt++;
		end
	end

	// hang guard, well above five cycles of slow memory
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	initial begin
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		chk("major rst", 32'h01, 32'(major));
		chk("level rst", 32'h0, 32'(lvl));
		for (int i = 0; i < 4; i++) begin
			pins <= rows[i].sw;
			press(rows[i].l, rows[i].s);
			rd(ctm_pkg::CTM_OFS_SWITCH, 32'(rows[i].sw), "sw");
			rd(ctm_pkg::CTM_OFS_LOCATION, 32'(rows[i].loc), "loc");
			rd(ctm_pkg::CTM_OFS_BUFFER, 32'(rows[i].bw), "buf");
			chk("addr", 32'(rows[i].loc), 32'(memReq.addr));
		end
		// read-only register and unmapped place
		wbx(1'b1, ctm_pkg::CTM_OFS_LOCATION, 32'hFFF, q);
		rd(ctm_pkg::CTM_OFS_LOCATION, 32'h5A5, "loc ro");
		rd(8'h1C, 32'h0, "unmapped");
		// fetch then execute through the captured address
		pins <= 12'h123;
		press(1'b1, 1'b0);
		run_cycle(8'h02, ctm_pkg::MS_EXECUTE, 1'b0);
		chk("capture", 32'(pat(12'h123)), 32'(readWord));
		rd(ctm_pkg::CTM_OFS_BUFFER, 32'(pat(12'h123)), "buf");
		rd(ctm_pkg::CTM_OFS_POINTER, 32'h124, "ptr");
		chk("major", 32'h04, 32'(major));
		chk("restore", 32'(pat(12'h123)), 32'(mdl.mem[12'h123]));
		run_cycle(8'h02, ctm_pkg::MS_FETCH, 1'b0);
		chk("exec", 32'(pat(pat(12'h123))), 32'(readWord));
		chk("major", 32'h01, 32'(major));
		// slow memory, skip at the top of memory, unknown next code
		pins <= 12'hFFF;
		press(1'b1, 1'b0);
		run_cycle(8'h96, ctm_pkg::ctm_major_e'(3'h7), 1'b1);
		chk("slow", 32'(pat(12'hFFF)), 32'(readWord));
		rd(ctm_pkg::CTM_OFS_POINTER, 32'h001, "skip");
		chk("major", 32'h01, 32'(major));
		// data break: single break state, address and data external
		brk <= 1'b1;
		ext <= 12'h0F0;
		run_cycle(8'h02, ctm_pkg::MS_FETCH, 1'b0);
		chk("brk major", 32'h20, 32'(major));
		brk <= 1'b0;
		run_cycle(8'h02, ctm_pkg::MS_FETCH, 1'b0);
		chk("brk read", 32'(pat(12'h0F0)), 32'(readWord));
		chk("brk write", 32'h0F0, 32'(mdl.mem[12'h0F0]));
		chk("major", 32'h01, 32'(major));
		chk("strobes", 32'h14, 32'(nStrobe));
		end_of_test();
	end
endmodule
